// File: ahome_defs.svh
`ifndef AHOME_DEFS_SVH
`define AHOME_DEFS_SVH

// Homing mode codes
`define AHOME_MODE_LIMIT_PLUS_INDEX 4'h3
`define AHOME_MODE_DIRECT_LOAD 4'h4
// Error codes reported on the error id output
`define AHOME_ERR_NONE 8'h00
`define AHOME_ERR_PARAM 8'h03
`define AHOME_ERR_MODE 8'h04
// Position width
`define AHOME_POS_W 32
// Pin input synchroniser depth
`define AHOME_SYNC_STAGES 2

`endif

// File: ahome_pkg.sv
`default_nettype none

package ahome_pkg;

    // Motion request towards the drive
    typedef struct packed {
        logic move_neg;
        logic move_pos;
        logic creep;
        logic decel_stop;
        logic hard_stop;
        logic go_target;
    } ahome_motion_s;

    // Status from the drive
    typedef struct packed {
        logic stopped;
        logic target_reached;
    } ahome_drive_s;

endpackage

`default_nettype wire

// File: ahome_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two flip-flop synchroniser for pin inputs
module ahome_sync
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;

    // ************************************************
    // Synchroniser chain
    // ************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// File: ahome_latch.sv
`timescale 1ns/100ps
`default_nettype none
`include "ahome_defs.svh"

// Position capture and target computation
module ahome_latch
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic capture,
    input wire logic [`AHOME_POS_W-1:0] position,
    input wire logic signed [`AHOME_POS_W-1:0] home_offset,
    output logic [`AHOME_POS_W-1:0] mech_home,
    output logic [`AHOME_POS_W-1:0] target
);

    // ************************************************
    // Mechanical home capture
    // ************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mech_home <= '0;
            target <= '0;
        end
        else if (capture)
        begin
            mech_home <= position;
            // Wraps on overflow; offset sign is the user's duty
            target <= position + home_offset;
        end
    end

endmodule
`default_nettype wire

// File: ahome_seq.sv
// Overview of operation
// - Index mode needs both inputs enabled, else error
// - Sequence chosen from config and sampled switches
// - Off the limit: search negative first
// - Limit hit: decelerate or hard stop
// - Then creep positive awaiting limit release
// - Limit release arms reference pulse watch
// - First pulse latches home, then decelerate
// - Final move to home plus offset
// - Already on limit: skip negative search
// - Direct mode loads position, no motion
// - Direct mode also sets homed flag
`timescale 1ns/100ps
`default_nettype none
`include "ahome_defs.svh"

module ahome_seq
    import ahome_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic homing_command,
    input wire logic [3:0] homing_mode,
    input wire logic [`AHOME_POS_W-1:0] commanded_position,
    input wire logic signed [`AHOME_POS_W-1:0] home_offset,
    input wire logic lower_limit_enable,
    input wire logic ref_pulse_enable,
    input wire logic hard_stop_enable,
    input wire logic lower_limit_pin,
    input wire logic ref_pulse_pin,
    input wire ahome_drive_s drive_status,
    input wire logic [`AHOME_POS_W-1:0] actual_position,
    output ahome_motion_s motion_q,
    output logic [`AHOME_POS_W-1:0] move_target_q,
    output logic position_load_q,
    output logic [`AHOME_POS_W-1:0] position_load_value_q,
    output logic axis_homed_q,
    output logic done_q,
    output logic busy_q,
    output logic error_q,
    output logic [7:0] error_id_q
);

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEARCH_NEG,
        ST_STOP_AT_LIMIT,
        ST_CREEP_POS,
        ST_WAIT_INDEX,
        ST_DECEL_HOME,
        ST_FINAL_MOVE
    } ahome_state_e;

    ahome_state_e state_q;
    // Synchronised pins
    logic [1:0] pins_s;
    logic limit_s;
    logic index_s;
    // Previous samples for edge detection
    logic limit_prev_q;
    logic index_prev_q;
    logic limit_fall;
    logic index_rise;
    logic cmd_prev_q;
    logic cmd_rise;
    logic capture;
    logic [`AHOME_POS_W-1:0] target_w;

    // ************************************************
    // Pin synchronisation and edges
    // ************************************************
    ahome_sync #(.WIDTH(2)) u_sync
    (
        .clk(clk),
        .resetn(resetn),
        .async_in({lower_limit_pin, ref_pulse_pin}),
        .sync_out(pins_s)
    );

    assign limit_s = pins_s[1];
    assign index_s = pins_s[0];
    assign limit_fall = limit_prev_q && !limit_s;
    assign index_rise = !index_prev_q && index_s;
    assign cmd_rise = homing_command && !cmd_prev_q;
    assign capture = (state_q == ST_WAIT_INDEX) && index_rise;

    // Edge history registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            limit_prev_q <= 1'b0;
            index_prev_q <= 1'b0;
            cmd_prev_q <= 1'b0;
        end
        else
        begin
            limit_prev_q <= limit_s;
            index_prev_q <= index_s;
            cmd_prev_q <= homing_command;
        end
    end

    // ************************************************
    // Home position capture
    // ************************************************
    ahome_latch u_latch
    (
        .clk(clk),
        .resetn(resetn),
        .capture(capture),
        .position(actual_position),
        .home_offset(home_offset),
        .mech_home(),
        .target(target_w)
    );

    // ************************************************
    // Sequencer
    // ************************************************
    // Command accepted on a rising edge while idle only; a
    // new edge mid-sequence is ignored so motion is never cut short.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            motion_q <= '0;
            move_target_q <= '0;
            position_load_q <= 1'b0;
            position_load_value_q <= '0;
            axis_homed_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            error_q <= 1'b0;
            error_id_q <= `AHOME_ERR_NONE;
        end
        else
        begin
            // Pulses default low
            done_q <= 1'b0;
            position_load_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    motion_q <= '0;
                    if (cmd_rise)
                    begin
                        error_q <= 1'b0;
                        error_id_q <= `AHOME_ERR_NONE;
                        if (homing_mode == `AHOME_MODE_DIRECT_LOAD)
                        begin
                            position_load_q <= 1'b1;
                            position_load_value_q <= commanded_position;
                            axis_homed_q <= 1'b1;
                            done_q <= 1'b1;
                        end
                        else if (homing_mode != `AHOME_MODE_LIMIT_PLUS_INDEX)
                        begin
                            // Unsupported method
                            error_q <= 1'b1;
                            error_id_q <= `AHOME_ERR_MODE;
                        end
                        else if (!lower_limit_enable || !ref_pulse_enable)
                        begin
                            error_q <= 1'b1;
                            error_id_q <= `AHOME_ERR_PARAM;
                        end
                        else if (limit_s)
                        begin
                            axis_homed_q <= 1'b0;
                            busy_q <= 1'b1;
                            motion_q.move_pos <= 1'b1;
                            motion_q.creep <= 1'b1;
                            state_q <= ST_CREEP_POS;
                        end
                        else
                        begin
                            axis_homed_q <= 1'b0;
                            busy_q <= 1'b1;
                            motion_q.move_neg <= 1'b1;
                            state_q <= ST_SEARCH_NEG;
                        end
                    end
                end
                ST_SEARCH_NEG:
                begin
                    if (limit_s)
                    begin
                        // stop style from hard stop setting
                        motion_q <= '0;
                        motion_q.hard_stop <= hard_stop_enable;
                        motion_q.decel_stop <= !hard_stop_enable;
                        state_q <= ST_STOP_AT_LIMIT;
                    end
                end
                ST_STOP_AT_LIMIT:
                begin
                    if (drive_status.stopped)
                    begin
                        motion_q <= '0;
                        motion_q.move_pos <= 1'b1;
                        motion_q.creep <= 1'b1;
                        state_q <= ST_CREEP_POS;
                    end
                end
                ST_CREEP_POS:
                begin
                    if (limit_fall)
                    begin
                        state_q <= ST_WAIT_INDEX;
                    end
                end
                ST_WAIT_INDEX:
                begin
                    if (index_rise)
                    begin
                        motion_q <= '0;
                        motion_q.decel_stop <= 1'b1;
                        state_q <= ST_DECEL_HOME;
                    end
                end
                ST_DECEL_HOME:
                begin
                    if (drive_status.stopped)
                    begin
                        motion_q <= '0;
                        motion_q.go_target <= 1'b1;
                        move_target_q <= target_w;
                        state_q <= ST_FINAL_MOVE;
                    end
                end
                ST_FINAL_MOVE:
                begin
                    if (drive_status.target_reached)
                    begin
                        motion_q <= '0;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        axis_homed_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    motion_q <= '0;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    sequence s_search_hit;
        state_q == ST_SEARCH_NEG && limit_s;
    endsequence

    chk_param_error: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_IDLE && cmd_rise && homing_mode == `AHOME_MODE_LIMIT_PLUS_INDEX
        && !(lower_limit_enable && ref_pulse_enable)
        |=> error_q && error_id_q == `AHOME_ERR_PARAM && state_q == ST_IDLE)
        else $error("param error not reported");

    chk_start_branch: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_IDLE && cmd_rise && homing_mode == `AHOME_MODE_LIMIT_PLUS_INDEX
        && lower_limit_enable && ref_pulse_enable
        |=> (state_q == (($past(limit_s)) ? ST_CREEP_POS : ST_SEARCH_NEG)) && busy_q)
        else $error("wrong start branch");

    chk_neg_first: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_SEARCH_NEG |-> motion_q.move_neg && !motion_q.move_pos)
        else $error("search not negative");

    chk_stop_style: assert property (@(posedge clk) disable iff (!resetn)
        s_search_hit |=> state_q == ST_STOP_AT_LIMIT
        && motion_q.hard_stop == $past(hard_stop_enable) && motion_q.decel_stop == !$past(hard_stop_enable))
        else $error("wrong stop style at limit");

    chk_creep_pos: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_CREEP_POS |-> motion_q.move_pos && motion_q.creep)
        else $error("creep not positive");

    chk_arm_index: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_CREEP_POS && limit_fall |=> state_q == ST_WAIT_INDEX)
        else $error("index watch not armed");

    chk_home_latch: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_WAIT_INDEX && index_rise |=> ##1 target_w == $past(actual_position, 2) + $past(home_offset, 2))
        else $error("home not latched");

    chk_final_target: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_DECEL_HOME && drive_status.stopped |=> motion_q.go_target && move_target_q == $past(target_w))
        else $error("final target wrong");

    chk_direct_load: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_IDLE && cmd_rise && homing_mode == `AHOME_MODE_DIRECT_LOAD
        |=> position_load_q && position_load_value_q == $past(commanded_position) && motion_q == '0)
        else $error("direct load wrong");

    chk_direct_homed: assert property (@(posedge clk) disable iff (!resetn)
        position_load_q |-> axis_homed_q && done_q)
        else $error("homed flag not set");

    chk_done_end: assert property (@(posedge clk) disable iff (!resetn)
        done_q |-> !busy_q && state_q == ST_IDLE)
        else $error("done while busy");

endmodule
`default_nettype wire

// File: ahome_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "ahome_defs.svh"

// Axis drive model: one count per cycle, lower limit switch, index every 16 counts
module ahome_drive_model
    import ahome_pkg::*;
#(
    parameter int LIMIT_POS = 10,
    parameter int DECEL_CYCLES = 3
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire ahome_motion_s motion,
    input wire logic [`AHOME_POS_W-1:0] target,
    input wire logic load,
    input wire logic [`AHOME_POS_W-1:0] load_value,
    output ahome_drive_s status,
    output logic [`AHOME_POS_W-1:0] pos_q,
    output logic limit_pin,
    output logic index_pin
);
    logic halted_q; // Axis brought to rest by a stop request
    logic [3:0] decel_q; // Cycles spent braking
    logic step_pos;
    logic step_neg;

    // ************************************************
    // Motion decode
    // ************************************************
    always_comb
    begin
        step_pos = 1'b0;
        step_neg = 1'b0;
        // The final move overrides the search requests
        if (motion.go_target)
        begin
            step_pos = $signed(target) > $signed(pos_q);
            step_neg = $signed(target) < $signed(pos_q);
        end
        else if (!halted_q && !motion.hard_stop)
        begin
            step_pos = motion.move_pos;
            step_neg = motion.move_neg;
        end
    end

    // Braking passes move requests for DECEL_CYCLES plus one cycles, but the sequencer drops them with decel_stop, so the axis halts at once
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            halted_q <= 1'b0;
            decel_q <= 4'h0;
        end
        else if (motion.hard_stop)
            halted_q <= 1'b1;
        else if (motion.decel_stop)
        begin
            if (decel_q == 4'(DECEL_CYCLES))
                halted_q <= 1'b1;
            else
                decel_q <= decel_q + 4'h1;
        end
        else
        begin
            halted_q <= 1'b0;
            decel_q <= 4'h0;
        end
    end

    // Position counter; a direct load wins over motion
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pos_q <= '0;
        else if (load)
            pos_q <= load_value;
        else if (step_pos)
            pos_q <= pos_q + 1;
        else if (step_neg)
            pos_q <= pos_q - 1;
    end

    assign status.stopped = !(step_pos || step_neg);
    assign status.target_reached = motion.go_target && (pos_q == target);
    assign limit_pin = $signed(pos_q) <= LIMIT_POS;
    assign index_pin = pos_q[3:0] == 4'h8;
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ahome_defs.svh"

module testbench
    import ahome_pkg::*;
;
    localparam logic [31:0] OFFS = 32'h0000_0064;
    // Index pin at 24 plus two counts of pin sync latency while creeping
    localparam logic [31:0] HOME_AT = 32'h0000_001a;
    logic clk;
    logic resetn;
    logic homing_command;
    logic [3:0] homing_mode;
    logic [31:0] commanded_position;
    logic lower_limit_enable;
    logic ref_pulse_enable;
    logic hard_stop_enable;
    logic limit_pin;
    logic index_pin;
    ahome_drive_s drive_status;
    logic [31:0] pos;
    ahome_motion_s motion_q;
    logic [31:0] move_target_q;
    logic position_load_q;
    logic [31:0] position_load_value_q;
    logic axis_homed_q;
    logic done_q;
    logic busy_q;
    logic error_q;
    logic [7:0] error_id_q;
    int err_total;
    int tests_run;
    int n;
    logic saw_neg, saw_pos_first, saw_hard, saw_any;

    ahome_seq dut_u (.clk(clk), .resetn(resetn), .homing_command(homing_command), .homing_mode(homing_mode),
        .commanded_position(commanded_position), .home_offset(OFFS), .lower_limit_enable(lower_limit_enable),
        .ref_pulse_enable(ref_pulse_enable), .hard_stop_enable(hard_stop_enable), .lower_limit_pin(limit_pin),
        .ref_pulse_pin(index_pin), .drive_status(drive_status), .actual_position(pos), .motion_q(motion_q),
        .move_target_q(move_target_q), .position_load_q(position_load_q),
        .position_load_value_q(position_load_value_q), .axis_homed_q(axis_homed_q), .done_q(done_q),
        .busy_q(busy_q), .error_q(error_q), .error_id_q(error_id_q));

    ahome_drive_model drive_u (.clk(clk), .resetn(resetn), .motion(motion_q), .target(move_target_q),
        .load(position_load_q), .load_value(position_load_value_q), .status(drive_status), .pos_q(pos),
        .limit_pin(limit_pin), .index_pin(index_pin));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Motion monitor: which request came first, and how the limit stop was made
    always @(posedge clk)
    begin
        if (motion_q.move_neg) saw_neg <= 1'b1;
        if (motion_q.move_pos && !saw_neg) saw_pos_first <= 1'b1;
        if (motion_q.hard_stop) saw_hard <= 1'b1;
        if (motion_q != '0) saw_any <= 1'b1;
    end

    // ************************************************
    // Compare and closing tasks
    // ************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One command: raise and wait for done or a fresh error; release_cmd lowers it
    task automatic run_cmd(input logic [3:0] mode, input logic le, input logic re, input logic hs,
                           input logic [31:0] cpos);
        saw_neg = 1'b0;
        saw_pos_first = 1'b0;
        saw_hard = 1'b0;
        saw_any = 1'b0;
        @(posedge clk);
        homing_mode <= mode;
        lower_limit_enable <= le;
        ref_pulse_enable <= re;
        hard_stop_enable <= hs;
        commanded_position <= cpos;
        homing_command <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (!(done_q === 1'b1 || (n >= 2 && error_q === 1'b1)) && n < 3000);
        if (n >= 3000)
        begin
            err_total++;
            $display("CHECK FAILED completion expected done seen timeout");
            test_done();
        end
    endtask

    task automatic release_cmd();
        @(posedge clk);
        homing_command <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic sc_param_errors();
        run_cmd(4'h3, 1'b0, 1'b1, 1'b0, 32'h0);
        cmp("limit off error id", {24'h0, `AHOME_ERR_PARAM}, {24'h0, error_id_q});
        cmp("limit off no motion", 32'h0, {31'h0, saw_any});
        release_cmd();
        run_cmd(4'h3, 1'b1, 1'b0, 1'b0, 32'h0);
        cmp("index off error id", {24'h0, `AHOME_ERR_PARAM}, {24'h0, error_id_q});
        cmp("index off error flag", 32'h1, {31'h0, error_q});
        release_cmd();
        run_cmd(4'h5, 1'b1, 1'b1, 1'b0, 32'h0);
        cmp("mode error id", {24'h0, `AHOME_ERR_MODE}, {24'h0, error_id_q});
        release_cmd();
    endtask

    task automatic sc_direct(input logic [31:0] cpos);
        run_cmd(4'h4, 1'b0, 1'b0, 1'b0, cpos);
        cmp("direct latency", 32'h1, n);
        cmp("direct load pulse", 32'h1, {31'h0, position_load_q});
        cmp("direct load value", cpos, position_load_value_q);
        cmp("direct homed", 32'h1, {31'h0, axis_homed_q});
        cmp("direct no motion", 32'h0, {31'h0, saw_any});
        release_cmd();
        cmp("direct position", cpos, pos);
    endtask

    // Full limit-plus-index homing; start position set by a direct load
    task automatic sc_index(input logic [31:0] start, input logic hs, input logic on_limit);
        sc_direct(start);
        run_cmd(4'h3, 1'b1, 1'b1, hs, 32'h0);
        cmp("done busy low", 32'h0, {31'h0, busy_q});
        cmp("homed after index", 32'h1, {31'h0, axis_homed_q});
        cmp("negative search", {31'h0, !on_limit}, {31'h0, saw_neg});
        cmp("positive first", {31'h0, on_limit}, {31'h0, saw_pos_first});
        cmp("hard stop used", {31'h0, hs && !on_limit}, {31'h0, saw_hard});
        // Index seen at 24 after the release at 11; capture lags by sync latency
        cmp("home past index", 32'h1, {31'h0, (move_target_q - OFFS) >= 24 && (move_target_q - OFFS) <= 32});
        cmp("final target", OFFS + HOME_AT, move_target_q);
        cmp("final position", OFFS + HOME_AT, pos);
        release_cmd();
    endtask

    // Reset in mid search: busy and the motion requests must drop back to rest at once
    task automatic sc_reset_mid();
        @(posedge clk);
        homing_mode <= 4'h3;
        lower_limit_enable <= 1'b1;
        ref_pulse_enable <= 1'b1;
        hard_stop_enable <= 1'b0;
        homing_command <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        cmp("busy before reset", 32'h1, {31'h0, busy_q});
        cmp("homed cleared at start", 32'h0, {31'h0, axis_homed_q});
        @(posedge clk);
        resetn <= 1'b0;
        homing_command <= 1'b0;
        @(posedge clk);
        #1;
        cmp("reset busy", 32'h0, {31'h0, busy_q});
        cmp("reset motion", 32'h0, {26'h0, motion_q});
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        resetn = 1'b0;
        homing_command = 1'b0;
        homing_mode = 4'h0;
        commanded_position = 32'h0;
        lower_limit_enable = 1'b0;
        ref_pulse_enable = 1'b0;
        hard_stop_enable = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        sc_param_errors();
        sc_direct(32'h8000_0001);
        sc_index(32'h0000_0028, 1'b0, 1'b0);
        sc_index(32'h0000_0030, 1'b1, 1'b0);
        sc_index(32'h0000_0005, 1'b0, 1'b1);
        sc_reset_mid();
        test_done();
    end
endmodule

`default_nettype wire
